//--- pkg/expansion_pkg.sv
// Behaviour
// - Module gets 32 data, six address lines
// - Active-low predecoded select per module base
// - Module uses strobes, acknowledge adds wait states
// - Select asserted about 50 to 100 ns; the board holds it five cycles (200 ns) with this module's acknowledge
// - Host and DSP accesses both reach module
// - Simple module latches 8 bits on select+write to OUT_REG_ADDR
// - Board reset clears module registers to zero, except DMA requests, which go inactive high
// - Active-low DMA request answered by grant
// - Three trigger and two spare shared lines
package expansion_pkg;
    localparam int DATA_W        = 32;
    localparam int ADDR_W        = 6;
    localparam int REG_COUNT     = 64;
    localparam int SYS_ADDR_W    = 16;
    localparam int SLOT_BASE_W   = 10;
    localparam int OUT_REG_W     = 8;
    localparam int TRIG_W        = 3;
    localparam int SPARE_W       = 2;
    localparam int DMA_W         = 2;
    localparam int CLK_PERIOD_NS = 40;
    // Select length per initiator, both round to two clock cycles
    localparam int HOST_SEL_NS   = 100;
    localparam int DSP_SEL_NS    = 50;
    localparam int HOST_SEL_CYC  = HOST_SEL_NS / CLK_PERIOD_NS;
    localparam int DSP_SEL_CYC   = (DSP_SEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_WAIT_CYC  = 8;
    localparam logic [SLOT_BASE_W-1:0] SLOT_BASE = 10'h100;
    localparam logic [OUT_REG_W-1:0]   OUT_RESET = 8'h00;
    localparam logic [ADDR_W-1:0]      OUT_REG_ADDR = 6'h00;
    localparam logic [ADDR_W-1:0]      STATUS_ADDR  = 6'h01;
endpackage : expansion_pkg

//--- pkg/expansion_if.sv
`timescale 1ns/1ps
interface expansion_if;
    import expansion_pkg::*;
    logic [ADDR_W-1:0] local_addr;
    logic [DATA_W-1:0] data_from_board;
    logic [DATA_W-1:0] data_from_module;
    logic              data_module_oe;
    logic              module_sel_n;
    logic              rd_n;
    logic              wr_n;
    logic              address_clock;
    logic              ack;
    logic [DMA_W-1:0]  dma_request_n;
    logic [DMA_W-1:0]  dma_grant_n;
    logic [TRIG_W-1:0] trig_out;
    logic [TRIG_W-1:0] trig_oe;
    logic [SPARE_W-1:0] spare_out;
    logic [SPARE_W-1:0] spare_oe;
    logic              board_rst_n;
    modport board (
        output local_addr, data_from_board, module_sel_n, rd_n, wr_n, address_clock,
        output dma_grant_n, board_rst_n,
        input  data_from_module, data_module_oe, ack, dma_request_n,
        input  trig_out, trig_oe, spare_out, spare_oe
    );
    modport module_end (
        input  local_addr, data_from_board, module_sel_n, rd_n, wr_n, address_clock,
        input  dma_grant_n, board_rst_n,
        output data_from_module, data_module_oe, ack, dma_request_n,
        output trig_out, trig_oe, spare_out, spare_oe
    );
endinterface : expansion_if

//--- design/expansion_board_end.sv
`timescale 1ns/1ps
module expansion_board_end (
    // Clock and reset
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    // Module side
    expansion_if.board                            port_b,
    // Host and DSP access requests
    input  wire logic                             host_req,
    input  wire logic                             dsp_req,
    input  wire logic                             req_write,
    input  wire logic [expansion_pkg::SYS_ADDR_W-1:0] req_addr,
    input  wire logic [expansion_pkg::DATA_W-1:0] req_wdata,
    output logic                                  req_done,
    output logic                                  req_err,
    output logic [expansion_pkg::DATA_W-1:0]      req_rdata,
    // DMA channel control
    input  wire logic [expansion_pkg::DMA_W-1:0]  dma_enable,
    output logic [expansion_pkg::DMA_W-1:0]       dma_active,
    // Shared lines as seen by the board
    output logic [expansion_pkg::TRIG_W-1:0]      trig_level,
    output logic [expansion_pkg::SPARE_W-1:0]     spare_level
);
    import expansion_pkg::*;

    // Sequencer states and the full register image
    typedef enum {ST_IDLE, ST_SEL, ST_WAIT} bstate_t;
    typedef struct packed {
        bstate_t            st;
        logic [3:0]         cnt;
        logic               is_host;
        logic               wr;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
        logic [DATA_W-1:0]  rdata;
        logic               done;
        logic               err;
        logic               sel_n;
        logic               rd_n;
        logic               wr_n;
        logic               adr_clk;
        logic [DMA_W-1:0]   grant_n;
        logic [2:0]         ack_s;
        logic [DMA_W-1:0]   dreq_a;
        logic [DMA_W-1:0]   dreq_b;
        logic [DMA_W-1:0]   dreq_c;
        logic [DMA_W-1:0]   active;
        logic               brst_n;
        logic [TRIG_W-1:0]  trig_a;
        logic [TRIG_W-1:0]  trig_b;
        logic [TRIG_W-1:0]  trig_c;
        logic [TRIG_W-1:0]  trig;
        logic [SPARE_W-1:0] spare_a;
        logic [SPARE_W-1:0] spare_b;
        logic [SPARE_W-1:0] spare_c;
        logic [SPARE_W-1:0] spare;
    } bstate_reg_t;

    // Registered state and its next value
    bstate_reg_t s_reg;
    bstate_reg_t s_next;
    // Resolved shared lines before synchronising
    logic [TRIG_W-1:0]  trig_wire;
    logic [SPARE_W-1:0] spare_wire;

    // Shared lines resolve as the module's drive ANDed with its enable, per line; board only listens
    assign trig_wire  = port_b.trig_out & port_b.trig_oe;
    assign spare_wire = port_b.spare_out & port_b.spare_oe;

    // Next state of the access sequencer, DMA and synchronisers
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.err = 1'b0;
        s_next.adr_clk = 1'b0;
        s_next.ack_s = {s_reg.ack_s[1:0], port_b.ack};
        s_next.dreq_a = port_b.dma_request_n;
        s_next.dreq_b = s_reg.dreq_a;
        s_next.dreq_c = s_reg.dreq_b;
        s_next.brst_n = 1'b1;  // Module reset trails board reset by one edge
        // Shared lines pass three stages; a level counts once stages two and three agree
        s_next.trig_a = trig_wire;
        s_next.trig_b = s_reg.trig_a;
        s_next.trig_c = s_reg.trig_b;
        s_next.spare_a = spare_wire;
        s_next.spare_b = s_reg.spare_a;
        s_next.spare_c = s_reg.spare_b;
        for (int i = 0; i < TRIG_W; i++) begin
            if (s_reg.trig_b[i] == s_reg.trig_c[i]) begin
                s_next.trig[i] = s_reg.trig_c[i];
            end
        end
        for (int i = 0; i < SPARE_W; i++) begin
            if (s_reg.spare_b[i] == s_reg.spare_c[i]) begin
                s_next.spare[i] = s_reg.spare_c[i];
            end
        end
        // Grant follows a filtered active-low request per channel
        for (int i = 0; i < DMA_W; i++) begin
            if (s_reg.dreq_b[i] == s_reg.dreq_c[i]) begin
                s_next.grant_n[i] = ~(dma_enable[i] & ~s_reg.dreq_c[i]);
                s_next.active[i] = dma_enable[i] & ~s_reg.dreq_c[i];
            end
        end
        case (s_reg.st)
            ST_IDLE: begin
                if (host_req || dsp_req) begin
                    s_next.is_host = host_req;
                    s_next.wr = req_write;
                    s_next.addr = req_addr[ADDR_W-1:0];
                    s_next.wdata = req_wdata;
                    // Only the own slot base starts a select, others fail at once
                    if (req_addr[SYS_ADDR_W-1:ADDR_W] == SLOT_BASE) begin
                        s_next.st = ST_SEL;
                        s_next.sel_n = 1'b0;
                        s_next.rd_n = req_write;
                        s_next.wr_n = ~req_write;
                        s_next.adr_clk = 1'b1;
                        s_next.cnt = host_req ? 4'(HOST_SEL_CYC - 1) : 4'(DSP_SEL_CYC - 1);
                    end else begin
                        s_next.err = 1'b1;
                        s_next.done = 1'b1;
                    end
                end
            end
            ST_SEL: begin
                // Minimum select length depends on the initiator
                if (s_reg.cnt != 4'h0) begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end else begin
                    s_next.st = ST_WAIT;
                    s_next.cnt = 4'(MAX_WAIT_CYC);
                end
            end
            ST_WAIT: begin
                // Module may stretch the access by holding acknowledge off
                if ((s_reg.ack_s[1] && s_reg.ack_s[2]) || s_reg.cnt == 4'h0) begin
                    s_next.st = ST_IDLE;
                    s_next.sel_n = 1'b1;
                    s_next.rd_n = 1'b1;
                    s_next.wr_n = 1'b1;
                    s_next.done = 1'b1;
                    s_next.err = ~(s_reg.ack_s[1] && s_reg.ack_s[2]);
                    // Undriven data lines read as zero
                    if (!s_reg.wr) begin
                        s_next.rdata = port_b.data_module_oe ? port_b.data_from_module : '0;
                    end
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg <= '{
                st:      ST_IDLE,
                cnt:     4'h0,
                is_host: 1'b0,
                wr:      1'b0,
                addr:    '0,
                wdata:   '0,
                rdata:   '0,
                done:    1'b0,
                err:     1'b0,
                sel_n:   1'b1,
                rd_n:    1'b1,
                wr_n:    1'b1,
                adr_clk: 1'b0,
                grant_n: '1,
                ack_s:   '0,
                dreq_a:  '1,
                dreq_b:  '1,
                dreq_c:  '1,
                active:  '0,
                brst_n:  1'b0,
                trig_a:  '0,
                trig_b:  '0,
                trig_c:  '0,
                trig:    '0,
                spare_a: '0,
                spare_b: '0,
                spare_c: '0,
                spare:   '0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs to the module and the user side
    assign port_b.local_addr      = s_reg.addr;
    assign port_b.data_from_board = s_reg.wdata;
    assign port_b.module_sel_n    = s_reg.sel_n;
    assign port_b.rd_n            = s_reg.rd_n;
    assign port_b.wr_n            = s_reg.wr_n;
    assign port_b.address_clock   = s_reg.adr_clk;
    assign port_b.dma_grant_n     = s_reg.grant_n;
    assign port_b.board_rst_n     = s_reg.brst_n;
    // Results toward the host and DSP side
    assign req_done    = s_reg.done;
    assign req_err     = s_reg.err;
    assign req_rdata   = s_reg.rdata;
    assign dma_active  = s_reg.active;
    assign trig_level  = s_reg.trig;
    assign spare_level = s_reg.spare;
endmodule : expansion_board_end

//--- design/expansion_module_end.sv
`timescale 1ns/1ps
module expansion_module_end (
    // Clock
    input  wire logic                              clock,
    // Board side
    expansion_if.module_end                        port_m,
    // User side
    input  wire logic [expansion_pkg::DMA_W-1:0]   dma_want,
    input  wire logic [expansion_pkg::TRIG_W-1:0]  trig_drive,
    input  wire logic [expansion_pkg::SPARE_W-1:0] spare_drive,
    output logic [expansion_pkg::OUT_REG_W-1:0]    user_out,
    output logic [expansion_pkg::DMA_W-1:0]        dma_granted
);
    import expansion_pkg::*;

    typedef struct packed {
        logic [OUT_REG_W-1:0] out;
        logic                 ack;
        logic                 oe;
        logic [DATA_W-1:0]    rdata;
        logic [DMA_W-1:0]     req_n;
        logic [DMA_W-1:0]     grant;
        logic [TRIG_W-1:0]    trig_oe;
        logic [SPARE_W-1:0]   spare_oe;
    } mstate_t;

    mstate_t m_reg;
    mstate_t m_next;
    logic    sel_rd;
    logic    sel_wr;

    // Predecoded select plus strobe, no address decoder needed
    assign sel_rd = ~port_m.module_sel_n & ~port_m.rd_n;
    assign sel_wr = ~port_m.module_sel_n & ~port_m.wr_n;

    // Next state
    always_comb begin
        m_next = m_reg;
        if (sel_wr && port_m.local_addr == OUT_REG_ADDR) begin
            m_next.out = port_m.data_from_board[OUT_REG_W-1:0];
        end
        m_next.ack = sel_rd | sel_wr;
        m_next.oe = sel_rd;
        m_next.rdata = (port_m.local_addr == STATUS_ADDR)
                     ? {{(DATA_W-DMA_W){1'b0}}, m_reg.grant}
                     : {{(DATA_W-OUT_REG_W){1'b0}}, m_reg.out};
        m_next.req_n = ~dma_want;
        m_next.grant = ~port_m.dma_grant_n;
        m_next.trig_oe = trig_drive;
        m_next.spare_oe = spare_drive;
    end

    // Board reset clears module state, except DMA requests, which go inactive high
    always_ff @(posedge clock) begin
        if (!port_m.board_rst_n) begin
            m_reg <= '{out: OUT_RESET, ack: 1'b0, oe: 1'b0, rdata: '0,
                       req_n: '1, grant: '0, trig_oe: '0, spare_oe: '0};
        end else begin
            m_reg <= m_next;
        end
    end

    // Drivers toward the board and the user side
    assign port_m.data_from_module = m_reg.rdata;
    assign port_m.data_module_oe   = m_reg.oe & sel_rd;
    assign port_m.ack              = m_reg.ack;
    assign port_m.dma_request_n    = m_reg.req_n;
    assign port_m.trig_out         = m_reg.trig_oe;
    assign port_m.trig_oe          = m_reg.trig_oe;
    assign port_m.spare_out        = m_reg.spare_oe;
    assign port_m.spare_oe         = m_reg.spare_oe;
    assign user_out    = m_reg.out;
    assign dma_granted = m_reg.grant;
endmodule : expansion_module_end

//--- dv/expansion_asserts.sv
`timescale 1ns/1ps
module expansion_asserts (
    // Clock and reset
    input wire logic                              clock,
    input wire logic                              rst_n,
    // Interface signals
    input wire logic [expansion_pkg::ADDR_W-1:0]  local_addr,
    input wire logic                              data_module_oe,
    input wire logic                              module_sel_n,
    input wire logic                              rd_n,
    input wire logic                              wr_n,
    input wire logic                              address_clock,
    input wire logic                              ack,
    input wire logic [expansion_pkg::DMA_W-1:0]   dma_request_n,
    input wire logic [expansion_pkg::DMA_W-1:0]   dma_grant_n
);
    import expansion_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Module data drive only near a selected read
    oe_on_read_a: assert property (
        data_module_oe |-> (!module_sel_n && !rd_n) || $past(!module_sel_n && !rd_n))
        else $error("module drives data outside a selected read");
    strobe_excl_a: assert property (
        !(!rd_n && !wr_n)) else $error("read and write strobes low together");
    strobe_sel_a: assert property (
        (!rd_n || !wr_n) |-> !module_sel_n) else $error("strobe without module select");
    address_clock_start_a: assert property (
        $fell(module_sel_n) |-> address_clock ##1 !address_clock)
        else $error("address clock not a one cycle pulse at access start");
    sel_min_a: assert property (
        $fell(module_sel_n) |-> !module_sel_n [*2]) else $error("select shorter than 2 cycles");
    sel_max_a: assert property (
        $fell(module_sel_n) |-> ##[1:20] module_sel_n) else $error("select never released");
    dma_grant_a: assert property (
        $fell(dma_grant_n[0]) |-> !dma_request_n[0] && $past(!dma_request_n[0]))
        else $error("grant without standing request");
    ack_sel_a: assert property (
        ack |-> !module_sel_n || $past(!module_sel_n)) else $error("ack outside select");
    addr_stable_a: assert property (
        (!module_sel_n && $past(!module_sel_n)) |-> $stable(local_addr))
        else $error("address moved during select");
endmodule : expansion_asserts

//--- dv/test_dsp_module_expansion_port.sv
`timescale 1ns/1ps
module test_dsp_module_expansion_port;
    import expansion_pkg::*;
    logic clock = 0, rst_n = 0, host_req = 0, dsp_req = 0, req_write = 0, req_done, req_err;
    logic [SYS_ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0, req_rdata, q;
    logic [DMA_W-1:0] dma_enable = '0, dma_want = '0, dma_active, dma_granted;
    logic [TRIG_W-1:0] trig_drive = '0, trig_level;
    logic [SPARE_W-1:0] spare_drive = '0, spare_level;
    logic [OUT_REG_W-1:0] user_out;
    logic [ADDR_W-1:0] seen_addr = '0;
    logic e;
    logic [DATA_W-1:0] d;
    int mismatches = 0, comparisons = 0;
    expansion_if bus ();
    expansion_board_end u_expansion_board_end (.clock(clock), .rst_n(rst_n), .port_b(bus),
        .host_req(host_req), .dsp_req(dsp_req), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_done(req_done), .req_err(req_err),
        .req_rdata(req_rdata), .dma_enable(dma_enable), .dma_active(dma_active),
        .trig_level(trig_level), .spare_level(spare_level));
    expansion_module_end u_expansion_module_end (.clock(clock), .port_m(bus),
        .dma_want(dma_want), .trig_drive(trig_drive), .spare_drive(spare_drive),
        .user_out(user_out), .dma_granted(dma_granted));
    expansion_asserts u_expansion_asserts (.clock(clock), .rst_n(rst_n),
        .local_addr(bus.local_addr), .data_module_oe(bus.data_module_oe),
        .module_sel_n(bus.module_sel_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .address_clock(bus.address_clock), .ack(bus.ack),
        .dma_request_n(bus.dma_request_n), .dma_grant_n(bus.dma_grant_n));
    // Clock and address capture at access start
    always #20 clock = ~clock;
    always @(posedge clock) if (bus.address_clock === 1'b1) seen_addr <= bus.local_addr;
    function automatic logic [15:0] slot_addr(input logic [ADDR_W-1:0] r);
        return {SLOT_BASE, r};
    endfunction : slot_addr
    // Expected register word for a read
    function automatic logic [DATA_W-1:0] exp_read(input logic [ADDR_W-1:0] r,
                                                   input logic [OUT_REG_W-1:0] o,
                                                   input logic [DMA_W-1:0] g);
        if (r == STATUS_ADDR) return {{(DATA_W-DMA_W){1'b0}}, g};
        return {{(DATA_W-OUT_REG_W){1'b0}}, o};
    endfunction : exp_read
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic final_report();
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // One access, request dropped after the taking edge
    task automatic access(input bit h, input bit w, input logic [15:0] a,
                          input logic [31:0] wd);
        int i;
        @(posedge clock);
        host_req <= h;
        dsp_req <= !h;
        req_write <= w;
        req_addr <= a;
        req_wdata <= wd;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            host_req <= 0;
            dsp_req <= 0;
            #1;
            if (req_done === 1'b1) break;
        end
        chk("req_done", 1, req_done);
        e = req_err;
        q = req_rdata;
    endtask : access
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 0;
        repeat (3) @(posedge clock);
        rst_n <= 1;
        #1;
        chk("user_out after reset", 0, user_out);
    endtask : do_reset
    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        final_report();
    end
    initial begin
        void'($urandom(95));
        do_reset();
        for (int k = 0; k < 8; k++) begin
            d = (k == 6) ? 32'hffffffff : (k == 7) ? 32'h0 : $urandom;
            access(k[0], 1, slot_addr(OUT_REG_ADDR), d);
            chk("write err", 0, e);
            chk("user_out", d[7:0], user_out);
            access(!k[0], 0, slot_addr(OUT_REG_ADDR), 32'h0);
            chk("read back", exp_read(OUT_REG_ADDR, d[7:0], 2'h0), q);
        end
        access(1, 1, 16'h0000 | 16'($urandom_range(63)), 32'h5a);
        chk("foreign base err", 1, e);
        chk("user_out kept", d[7:0], user_out);
        access(0, 0, slot_addr(STATUS_ADDR), 32'h0);
        chk("local_addr", STATUS_ADDR, seen_addr);
        chk("status idle", exp_read(STATUS_ADDR, 8'h0, 2'h0), q);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            dma_enable <= (k == 0) ? 2'h3 : 2'($urandom);
            dma_want <= (k == 0) ? 2'h3 : 2'($urandom);
            trig_drive <= 3'($urandom);
            spare_drive <= 2'($urandom);
            repeat (12) @(posedge clock);
            #1;
            chk("dma_granted", dma_enable & dma_want, dma_granted);
            chk("dma_active", dma_enable & dma_want, dma_active);
            chk("trig_level", trig_drive, trig_level);
            chk("spare_level", spare_drive, spare_level);
            access(k[0], 0, slot_addr(STATUS_ADDR), 32'h0);
            chk("status read", exp_read(STATUS_ADDR, 8'h0, dma_enable & dma_want), q);
            @(posedge clock);
            dma_want <= 2'h0;
            repeat (12) @(posedge clock);
        end
        do_reset();
        final_report();
    end
endmodule : test_dsp_module_expansion_port
